// ---- lcd_port_cfg.svh ----
`ifndef LCD_PORT_CFG_SVH
`define LCD_PORT_CFG_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS   8
`define EXEC_TIME_NS    1000
`define EXEC_CYCLES     ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXEC_CNT_W      8

// ==========================================================
// Instruction fields
`define IR_SET_DISP_BIT 7
`define IR_SET_GLYPH_BIT 6
`define IR_FUNC_BIT     5
`define IR_WIDTH_BIT    4
`define IR_ENTRY_BIT    2
`define IR_ENTRY_MASK   8'hFC
`define IR_ENTRY_CODE   8'h04
`define IR_DIR_BIT      1
`define IR_HOME_BIT     1
`define IR_CLEAR_CODE   8'h01
`define GLYPH_ADDR_W    6

// ==========================================================
// Reset values and status layout
`define PTR_RESET       7'h00
`define WIDTH_RESET     1'b1
`define DIR_RESET       1'b1
`define BYTE_RESET      8'h00
`define NIB_RESET       4'h0
`define STATUS_BUSY_BIT 7

`endif

// ---- lcd_port_pkg.sv ----
package lcd_port_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [6:0] ptr_t;
	typedef logic [3:0] nib_t;
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_FETCH = 2'b01,
		SEQ_LOAD  = 2'b10
	} seq_t;
endpackage

// ---- char_ram_store.sv ----
`timescale 1ns/1ns
`include "lcd_port_cfg.svh"

module char_ram_store (
	input  wire logic                 sys_clk,    // System clock
	input  wire logic                 wr_en,      // Write strobe
	input  wire logic                 wr_glyph,   // Write targets glyph RAM
	input  wire lcd_port_pkg::ptr_t   wr_addr,    // Write address
	input  wire lcd_port_pkg::byte_t  wr_data,    // Write data
	input  wire logic                 rd_glyph,   // Read targets glyph RAM
	input  wire lcd_port_pkg::ptr_t   rd_addr,    // Read address
	output lcd_port_pkg::byte_t       rd_data,    // Read data, one cycle late
	input  wire lcd_port_pkg::ptr_t   scan_addr,  // Refresh read address
	output lcd_port_pkg::byte_t       scan_data   // Refresh read data
);
	lcd_port_pkg::byte_t disp_mem  [0:127];
	lcd_port_pkg::byte_t glyph_mem [0:63];

	always_ff @(posedge sys_clk) begin
		if (wr_en && wr_glyph)
			glyph_mem[wr_addr[`GLYPH_ADDR_W-1:0]] <= wr_data;
		else if (wr_en)
			disp_mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge sys_clk) begin
		rd_data   <= rd_glyph ? glyph_mem[rd_addr[`GLYPH_ADDR_W-1:0]] : disp_mem[rd_addr];
		scan_data <= disp_mem[scan_addr];
	end
endmodule // char_ram_store

// ---- char_lcd_host_bus_port.sv ----
`timescale 1ns/1ns
`include "lcd_port_cfg.svh"
// Functional notes
// - Bus runs 4 or 8 bits per width bit
// - Two 8-bit registers: staging and instruction
// - Staging register carries every RAM data byte
// - Last address instruction or clear picks target RAM
// - After data read, prefetch next address
// - After data write, copy byte into RAM
// - Instruction register is write-only to host
// - Register select chooses register, both widths
// - Select/read decode: instr, status, data
// - Busy refuses instructions; host polls first
// - Pointer steps by one per data access

module char_lcd_host_bus_port (
	input  wire logic                 sys_clk,         // System clock
	input  wire logic                 sys_rst,         // Sync reset, active high
	input  wire logic                 register_select, // 0 instruction, 1 data
	input  wire logic                 read_write,      // 1 read, 0 write
	input  wire logic                 enable,          // Host strobe
	input  wire lcd_port_pkg::byte_t  db_in,           // Data bus in
	output lcd_port_pkg::byte_t       db_out,          // Data bus out
	output logic                      db_oe,           // Data bus drive enable
	output lcd_port_pkg::byte_t       instr_code,      // Last accepted instruction
	output logic                      instr_strobe,    // Pulse per accepted instruction
	output logic                      bus_width_select,// 1 = 8-bit bus
	output logic                      busy_indicator,  // Internal operation running
	input  wire lcd_port_pkg::ptr_t   scan_addr,       // Refresh read address
	output lcd_port_pkg::byte_t       scan_data        // Refresh read data
);
	// ==========================================================
	// Strobe sampling and nibble pairing
	logic                   e_prev_r;
	logic                   nib_phase_r;
	lcd_port_pkg::nib_t     hi_nib_r;
	logic                   e_fall;
	logic                   acc_done;
	lcd_port_pkg::byte_t    acc_byte;

	assign e_fall   = e_prev_r && !enable;
	assign acc_done = e_fall && (bus_width_select || nib_phase_r);
	assign acc_byte = bus_width_select ? db_in : {hi_nib_r, db_in[7:4]};

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			e_prev_r <= 1'b0;
		else
			e_prev_r <= enable;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			nib_phase_r <= 1'b0;
			hi_nib_r    <= `NIB_RESET;
		end else if (bus_width_select) begin
			nib_phase_r <= 1'b0;
		end else if (e_fall) begin
			nib_phase_r <= !nib_phase_r;
			if (!nib_phase_r)
				hi_nib_r <= db_in[7:4];
		end
	end

	// ==========================================================
	// Access decode
	logic instr_acc;
	logic data_wr_acc;
	logic data_rd_acc;

	assign instr_acc   = acc_done && !register_select && !read_write && !busy_indicator;
	assign data_wr_acc = acc_done && register_select && !read_write && !busy_indicator;
	assign data_rd_acc = acc_done && register_select && read_write && !busy_indicator;

	function automatic lcd_port_pkg::ptr_t ptr_step(input lcd_port_pkg::ptr_t p, input logic up);
		ptr_step = up ? lcd_port_pkg::ptr_t'(p + 7'h01) : lcd_port_pkg::ptr_t'(p - 7'h01);
	endfunction

	// ==========================================================
	// Instruction holding register and settings
	logic                  dir_up_r;
	logic                  ram_glyph_r;
	lcd_port_pkg::ptr_t    addr_ptr_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			instr_code   <= `BYTE_RESET;
			instr_strobe <= 1'b0;
		end else begin
			instr_strobe <= instr_acc;
			if (instr_acc)
				instr_code <= acc_byte;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_width_select <= `WIDTH_RESET;
			dir_up_r         <= `DIR_RESET;
			ram_glyph_r      <= 1'b0;
		end else if (instr_acc) begin
			if (acc_byte[`IR_SET_DISP_BIT])
				ram_glyph_r <= 1'b0;
			else if (acc_byte[`IR_SET_GLYPH_BIT])
				ram_glyph_r <= 1'b1;
			else if (acc_byte[`IR_FUNC_BIT])
				bus_width_select <= acc_byte[`IR_WIDTH_BIT];
			// Masked match on bits 7:2, bits 1:0 free: display and shift codes also carry this bit
			else if ((acc_byte & `IR_ENTRY_MASK) == `IR_ENTRY_CODE)
				dir_up_r <= acc_byte[`IR_DIR_BIT];
			else if (acc_byte == `IR_CLEAR_CODE) begin
				dir_up_r    <= 1'b1;
				ram_glyph_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Address pointer
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			addr_ptr_r <= `PTR_RESET;
		else if (instr_acc && acc_byte[`IR_SET_DISP_BIT])
			addr_ptr_r <= acc_byte[6:0];
		else if (instr_acc && acc_byte[`IR_SET_GLYPH_BIT])
			addr_ptr_r <= {1'b0, acc_byte[`GLYPH_ADDR_W-1:0]};
		else if (instr_acc && (acc_byte == `IR_CLEAR_CODE || acc_byte[7:2] == 6'h00 && acc_byte[`IR_HOME_BIT]))
			addr_ptr_r <= `PTR_RESET;
		else if (data_wr_acc || data_rd_acc)
			addr_ptr_r <= ptr_step(addr_ptr_r, dir_up_r);
	end

	// ==========================================================
	// Staging register and RAM sequencing
	lcd_port_pkg::seq_t    seq_r;
	lcd_port_pkg::byte_t   staging_r;
	lcd_port_pkg::byte_t   ram_rdata;
	logic                  ram_we_r;
	logic                  ram_wglyph_r;
	lcd_port_pkg::ptr_t    ram_waddr_r;
	logic                  start_fetch;

	assign start_fetch = data_wr_acc || data_rd_acc
		|| instr_acc && (acc_byte[`IR_SET_DISP_BIT] || acc_byte[`IR_SET_GLYPH_BIT]);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			seq_r <= lcd_port_pkg::SEQ_IDLE;
		end else begin
			case (seq_r)
				lcd_port_pkg::SEQ_IDLE:  if (start_fetch) seq_r <= lcd_port_pkg::SEQ_FETCH;
				lcd_port_pkg::SEQ_FETCH: seq_r <= lcd_port_pkg::SEQ_LOAD;
				lcd_port_pkg::SEQ_LOAD:  seq_r <= lcd_port_pkg::SEQ_IDLE;
				default:                 seq_r <= lcd_port_pkg::SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			staging_r <= `BYTE_RESET;
		else if (data_wr_acc)
			staging_r <= acc_byte;
		else if (seq_r == lcd_port_pkg::SEQ_LOAD)
			staging_r <= ram_rdata;
	end

	// Write lands one cycle after the strobe, using the pre-step pointer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ram_we_r     <= 1'b0;
			ram_wglyph_r <= 1'b0;
			ram_waddr_r  <= `PTR_RESET;
		end else begin
			ram_we_r <= data_wr_acc;
			if (data_wr_acc) begin
				ram_wglyph_r <= ram_glyph_r;
				ram_waddr_r  <= addr_ptr_r;
			end
		end
	end

	char_ram_store u_ram (
		.sys_clk   (sys_clk),
		.wr_en     (ram_we_r),
		.wr_glyph  (ram_wglyph_r),
		.wr_addr   (ram_waddr_r),
		.wr_data   (staging_r),
		.rd_glyph  (ram_glyph_r),
		.rd_addr   (addr_ptr_r),
		.rd_data   (ram_rdata),
		.scan_addr (scan_addr),
		.scan_data (scan_data)
	);

	// ==========================================================
	// Busy indicator
	logic [`EXEC_CNT_W-1:0] exec_cnt_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			exec_cnt_r <= '0;
		else if (instr_acc)
			exec_cnt_r <= `EXEC_CNT_W'(`EXEC_CYCLES);
		else if (exec_cnt_r != '0)
			exec_cnt_r <= exec_cnt_r - `EXEC_CNT_W'(1);
	end

	// Registered, so an access in the same cycle as the start still sees old busy
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			busy_indicator <= 1'b0;
		else
			busy_indicator <= instr_acc || start_fetch || exec_cnt_r > `EXEC_CNT_W'(1)
				|| seq_r == lcd_port_pkg::SEQ_FETCH;
	end

	// ==========================================================
	// Read data path
	lcd_port_pkg::byte_t rd_byte;

	// Instruction register never feeds the read mux
	assign rd_byte = register_select ? staging_r : {busy_indicator, addr_ptr_r};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			db_oe  <= 1'b0;
			db_out <= `BYTE_RESET;
		end else begin
			db_oe <= enable && read_write;
			if (bus_width_select)
				db_out <= rd_byte;
			else if (!nib_phase_r)
				db_out <= {rd_byte[7:4], `NIB_RESET};
			else
				db_out <= {rd_byte[3:0], `NIB_RESET};
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence fetch_seq;
		seq_r == lcd_port_pkg::SEQ_FETCH ##1 seq_r == lcd_port_pkg::SEQ_LOAD;
	endsequence

	busy_refuse_instr_a: assert property (busy_indicator && acc_done |=> !instr_strobe)
		else $error("Instruction taken while busy");
	busy_holds_a: assert property (instr_acc |=> busy_indicator [*8])
		else $error("Busy dropped too early");
	ptr_step_a: assert property (data_wr_acc || data_rd_acc |=>
		addr_ptr_r == ($past(dir_up_r) ? $past(addr_ptr_r) + 7'h01 : $past(addr_ptr_r) - 7'h01))
		else $error("Pointer did not step by one");
	read_prefetch_a: assert property (data_rd_acc |=> fetch_seq ##1 staging_r == $past(ram_rdata))
		else $error("Next byte not loaded after read");
	write_copy_a: assert property (data_wr_acc |=> ram_we_r && ram_waddr_r == $past(addr_ptr_r)
		&& staging_r == $past(acc_byte))
		else $error("Written byte not copied to RAM");
	glyph_select_a: assert property (instr_acc && !acc_byte[7] && acc_byte[6] |=>
		ram_glyph_r && addr_ptr_r[5:0] == $past(acc_byte[5:0]))
		else $error("Glyph RAM not selected");
	width_set_a: assert property (instr_acc && acc_byte[7:5] == 3'h1 |=> bus_width_select == $past(acc_byte[4]))
		else $error("Bus width not taken");
	nibble_upper_a: assert property (!bus_width_select && e_fall && !nib_phase_r |=>
		hi_nib_r == $past(db_in[7:4]) && nib_phase_r)
		else $error("Upper nibble not captured first");
	drive_on_read_a: assert property (db_oe |-> $past(read_write) && $past(enable))
		else $error("Bus driven outside a read");
endmodule // char_lcd_host_bus_port

// ---- host_model.sv ----
`timescale 1ns/1ns

module host_model (
	input  wire logic                sys_clk,         // System clock
	input  wire lcd_port_pkg::byte_t db_out,          // Read data from port
	output logic                     register_select, // Register choice
	output logic                     read_write,      // 1 read, 0 write
	output logic                     enable,          // Host strobe
	output lcd_port_pkg::byte_t      db_in            // Write data
);
	logic wide = 1'b1;

	initial begin
		register_select = 1'b0;
		read_write = 1'b0;
		enable = 1'b0;
		db_in = 8'h00;
	end

	// ==========================================================
	// Bus cycles
	// Released bus shows the inverse of the last value from one cycle after the strobe falls
	task automatic strobe(input logic rs, rw, input lcd_port_pkg::byte_t d, output lcd_port_pkg::byte_t q);
		@(negedge sys_clk);
		register_select = rs;
		read_write = rw;
		db_in = d;
		enable = 1'b1;
		repeat (3) @(negedge sys_clk);
		q = db_out;
		enable = 1'b0;
		// Data held across the falling strobe, where the port samples it
		@(negedge sys_clk);
		db_in = ~d;
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic xfer(input logic rs, rw, input lcd_port_pkg::byte_t d, output lcd_port_pkg::byte_t q);
		lcd_port_pkg::byte_t hi;
		lcd_port_pkg::byte_t lo;
		if (wide) begin
			strobe(rs, rw, d, q);
		end else begin
			strobe(rs, rw, {d[7:4], 4'h0}, hi);
			strobe(rs, rw, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end
	endtask

	task automatic poll(output lcd_port_pkg::byte_t st);
		st = 8'h80;
		for (int i = 0; i < 300 && st[7] !== 1'b0; i++) begin
			xfer(1'b0, 1'b1, 8'h00, st);
		end
	endtask

	task automatic put(input logic rs, input lcd_port_pkg::byte_t d);
		lcd_port_pkg::byte_t st;
		poll(st);
		xfer(rs, 1'b0, d, st);
	endtask

	task automatic get(output lcd_port_pkg::byte_t q);
		lcd_port_pkg::byte_t st;
		poll(st);
		xfer(1'b1, 1'b1, 8'h00, q);
	endtask
endmodule // host_model

// ---- char_lcd_host_bus_port_tb_top.sv ----
`timescale 1ns/1ns

module char_lcd_host_bus_port_tb_top;
	logic                sys_clk;
	logic                sys_rst;
	logic                register_select;
	logic                read_write;
	logic                enable;
	lcd_port_pkg::byte_t db_in;
	lcd_port_pkg::byte_t db_out;
	logic                db_oe;
	lcd_port_pkg::byte_t instr_code;
	logic                instr_strobe;
	logic                bus_width_select;
	logic                busy_indicator;
	lcd_port_pkg::ptr_t  scan_addr;
	lcd_port_pkg::byte_t scan_data;
	lcd_port_pkg::byte_t q;
	int                  bad_count = 0;
	int                  checks_done = 0;
	int                  strobes = 0;
	int                  s;

	char_lcd_host_bus_port u_char_lcd_host_bus_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.register_select(register_select), .read_write(read_write), .enable(enable), .db_in(db_in),
		.db_out(db_out), .db_oe(db_oe), .instr_code(instr_code), .instr_strobe(instr_strobe),
		.bus_width_select(bus_width_select), .busy_indicator(busy_indicator), .scan_addr(scan_addr),
		.scan_data(scan_data));

	host_model u_host_model (.sys_clk(sys_clk), .db_out(db_out), .register_select(register_select),
		.read_write(read_write), .enable(enable), .db_in(db_in));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (instr_strobe === 1'b1) begin
			strobes++;
		end
	end

	// ==========================================================
	// Helpers
	task automatic check(input string name, input lcd_port_pkg::byte_t seen, exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic scan(input lcd_port_pkg::ptr_t a, input lcd_port_pkg::byte_t exp);
		@(negedge sys_clk);
		scan_addr = a;
		repeat (2) @(negedge sys_clk);
		check("scan", scan_data, exp);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		check("width", {7'h00, bus_width_select}, 8'h01);
		check("busy", {7'h00, busy_indicator}, 8'h00);
		check("oe", {7'h00, db_oe}, 8'h00);
		$display("Done reset");
	endtask

	task automatic t_rw();
		u_host_model.put(1'b0, 8'h90);
		u_host_model.poll(q);
		check("pointer", q, 8'h10);
		u_host_model.put(1'b1, 8'hA5);
		u_host_model.put(1'b1, 8'h3C);
		u_host_model.poll(q);
		check("pointer", q, 8'h12);
		scan(7'h10, 8'hA5);
		u_host_model.put(1'b0, 8'h90);
		u_host_model.get(q);
		check("read", q, 8'hA5);
		u_host_model.get(q);
		check("read", q, 8'h3C);
		$display("Done write and read");
	endtask

	task automatic t_refuse();
		s = strobes;
		u_host_model.put(1'b0, 8'h84);
		u_host_model.xfer(1'b0, 1'b0, 8'h85, q);
		u_host_model.poll(q);
		check("pointer", q, 8'h04);
		check("code", instr_code, 8'h84);
		check("strobes", 8'(strobes - s), 8'h01);
		$display("Done busy refusal");
	endtask

	task automatic t_down_glyph();
		u_host_model.put(1'b0, 8'h04);
		u_host_model.put(1'b0, 8'hA0);
		u_host_model.put(1'b1, 8'h5A);
		u_host_model.poll(q);
		check("pointer", q, 8'h1F);
		u_host_model.put(1'b0, 8'h06);
		u_host_model.put(1'b0, 8'h83);
		u_host_model.put(1'b1, 8'h77);
		u_host_model.put(1'b0, 8'h43);
		u_host_model.put(1'b1, 8'h11);
		u_host_model.put(1'b0, 8'h43);
		u_host_model.get(q);
		check("glyph", q, 8'h11);
		scan(7'h03, 8'h77);
		u_host_model.put(1'b0, 8'h04);
		u_host_model.put(1'b0, 8'h01);
		u_host_model.poll(q);
		check("pointer", q, 8'h00);
		u_host_model.put(1'b0, 8'h0C);
		u_host_model.put(1'b1, 8'h66);
		u_host_model.put(1'b1, 8'h67);
		u_host_model.poll(q);
		check("pointer", q, 8'h02);
		scan(7'h01, 8'h67);
		u_host_model.put(1'b0, 8'h02);
		u_host_model.poll(q);
		check("pointer", q, 8'h00);
		$display("Done direction and glyph");
	endtask

	task automatic t_nibble();
		u_host_model.put(1'b0, 8'h20);
		u_host_model.wide = 1'b0;
		check("width", {7'h00, bus_width_select}, 8'h00);
		u_host_model.put(1'b0, 8'h88);
		check("code", instr_code, 8'h88);
		u_host_model.put(1'b1, 8'hC4);
		u_host_model.poll(q);
		check("pointer", q, 8'h09);
		u_host_model.put(1'b0, 8'h88);
		u_host_model.get(q);
		check("read", q, 8'hC4);
		u_host_model.put(1'b0, 8'h30);
		u_host_model.wide = 1'b1;
		u_host_model.poll(q);
		check("width", {7'h00, bus_width_select}, 8'h01);
		$display("Done nibble mode");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		sys_rst = 1'b1;
		scan_addr = 7'h00;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		t_reset();
		t_rw();
		t_refuse();
		t_down_glyph();
		t_nibble();
		complete_run();
	end

	// Run needs about 3000 cycles; generous margin
	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
endmodule // char_lcd_host_bus_port_tb_top
